// file: rtl/ddr_sio_sram_pkg.sv
// shared constants for the double-data-rate separate-I/O sram port
package ddr_sio_sram_pkg;

    // ****************************************************************
    // data path variants
    // ****************************************************************
    localparam int WIDTH_X8 = 8;
    localparam int WIDTH_X9 = 9;
    localparam int WIDTH_X18 = 18;
    localparam int WIDTH_X36 = 36;
    localparam int NIBBLE_W = 4;
    localparam int BYTE_LANE_W = 9;
    localparam int BURST_LEN = 2;

    // ****************************************************************
    // address widths per variant
    // ****************************************************************
    localparam int ADDR_W_NARROW = 21;
    localparam int ADDR_W_X18 = 20;
    localparam int ADDR_W_X36 = 19;

    // ****************************************************************
    // clock and phase
    // ****************************************************************
    localparam int CORE_CLK_PERIOD_NS = 25;

    // capture point inside one input clock period
    typedef enum logic {
        PH_TRUE,
        PH_COMP
    } phase_t;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic RST_OE = 1'b0;
    localparam logic RST_ECHO = 1'b0;
    localparam logic RST_PEND = 1'b0;

endpackage : ddr_sio_sram_pkg

// file: rtl/lane_merge.sv
// merges new write data into an old word lane by lane under active-low selects
module lane_merge #(
    parameter int LANE_W = 9,
    parameter int LANES = 4
) (
    input wire logic [LANE_W*LANES-1:0] old_word_i,
    input wire logic [LANE_W*LANES-1:0] new_word_i,
    input wire logic [LANES-1:0] sel_n_i,
    output logic [LANE_W*LANES-1:0] merged_o
);

    // ****************************************************************
    // per-lane select
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            // deselected lane keeps the stored contents
            assign merged_o[g*LANE_W +: LANE_W] = sel_n_i[g] ? old_word_i[g*LANE_W +: LANE_W]
                                                             : new_word_i[g*LANE_W +: LANE_W];
        end
    endgenerate

endmodule : lane_merge

// file: rtl/ddr_sio_sram_port.sv
// port logic and storage of a two-word-burst double-data-rate sram with separate i/o

// Notes on behaviour
// - every transaction moves exactly two words
// - read/write select high reads, low writes
// - accesses start only on true edge
// - address sampled on true edge, shared bus
// - two array halves; address width per variant
// - address ignored unless load strobe selects
// - x8 uses two nibble selects, bits 3:0/7:4
// - nibble selects sampled with their data word
// - byte selects gate 9-bit lanes each
// - byte selects sampled on both edges
// - read data on output edges, or input
// - read outputs released when no read
// - output clock pair times read data
// - complementary edge is second capture point
// - write word0 on true, word1 on complementary
// - free-running echo strobe pair follows output clock, or input in single clock mode
module ddr_sio_sram_port #(
    parameter int DATA_W = ddr_sio_sram_pkg::WIDTH_X36,
    parameter int ADDR_W = (DATA_W == ddr_sio_sram_pkg::WIDTH_X36) ?
                           ddr_sio_sram_pkg::ADDR_W_X36 :
                           (DATA_W == ddr_sio_sram_pkg::WIDTH_X18) ?
                           ddr_sio_sram_pkg::ADDR_W_X18 :
                           ddr_sio_sram_pkg::ADDR_W_NARROW,
    parameter int LANE_W = (DATA_W == ddr_sio_sram_pkg::WIDTH_X8) ?
                           ddr_sio_sram_pkg::NIBBLE_W : ddr_sio_sram_pkg::BYTE_LANE_W,
    parameter int SEL_W = DATA_W / LANE_W
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic load_strobe_n_i,
    input wire logic read_write_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [SEL_W-1:0] byte_write_sel_n_i,
    input wire logic single_clock_mode_i,
    input wire logic out_clk_rise_i,
    input wire logic out_clk_n_rise_i,
    output logic [DATA_W-1:0] rdata_o,
    output logic rdata_oe_o,
    output logic echo_strobe_o,
    output logic echo_strobe_n_o,
    output logic phase_comp_o
);

    // ****************************************************************
    // storage: one half per burst word
    // ****************************************************************
    localparam int DEPTH = 2 ** ADDR_W;

    logic [DATA_W-1:0] mem_w0 [DEPTH];
    logic [DATA_W-1:0] mem_w1 [DEPTH];

    // ****************************************************************
    // state
    // ****************************************************************
    ddr_sio_sram_pkg::phase_t phase_q, phase_d;

    logic wr_pend_q, wr_pend_d;
    logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
    logic [DATA_W-1:0] wr_word0_q, wr_word0_d;
    logic [SEL_W-1:0] wr_sel0_q, wr_sel0_d;

    logic rd_pend_q, rd_pend_d;
    logic [DATA_W-1:0] rd_buf0_q, rd_buf0_d;
    logic [DATA_W-1:0] rd_buf1_q, rd_buf1_d;
    logic [DATA_W-1:0] rd_hold1_q, rd_hold1_d;
    logic drive1_q, drive1_d;

    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic oe_q, oe_d;
    logic echo_q, echo_d;

    // ****************************************************************
    // decoded strobes
    // ****************************************************************
    logic true_edge;
    logic comp_edge;
    logic load_read;
    logic load_write;
    logic commit_write;
    logic out_true;
    logic out_comp;
    logic [DATA_W-1:0] merged0;
    logic [DATA_W-1:0] merged1;

    // true and complementary capture points alternate each core cycle
    assign true_edge = (phase_q == ddr_sio_sram_pkg::PH_TRUE);
    assign comp_edge = (phase_q == ddr_sio_sram_pkg::PH_COMP);

    // a transaction is defined only by a low load strobe on a true edge
    assign load_read = true_edge && !load_strobe_n_i && read_write_i;
    assign load_write = true_edge && !load_strobe_n_i && !read_write_i;

    // second burst word of a write arrives on the complementary edge
    assign commit_write = comp_edge && wr_pend_q;

    // output pair or, in single clock mode, the input pair times read data
    assign out_true = single_clock_mode_i ? true_edge : out_clk_rise_i;
    assign out_comp = single_clock_mode_i ? comp_edge : out_clk_n_rise_i;

    // ****************************************************************
    // lane masking of both burst words
    // ****************************************************************
    // word 0 carries the selects sampled with it on the true edge
    lane_merge #(
        .LANE_W(LANE_W),
        .LANES(SEL_W)
    ) u_merge0 (
        .old_word_i(mem_w0[wr_addr_q]),
        .new_word_i(wr_word0_q),
        .sel_n_i(wr_sel0_q),
        .merged_o(merged0)
    );

    // word 1 carries the selects present on the complementary edge
    lane_merge #(
        .LANE_W(LANE_W),
        .LANES(SEL_W)
    ) u_merge1 (
        .old_word_i(mem_w1[wr_addr_q]),
        .new_word_i(wdata_i),
        .sel_n_i(byte_write_sel_n_i),
        .merged_o(merged1)
    );

    // ****************************************************************
    // write capture: next values
    // ****************************************************************
    // address, first word and its selects are taken only on a write load
    always_comb begin
        phase_d = comp_edge ? ddr_sio_sram_pkg::PH_TRUE : ddr_sio_sram_pkg::PH_COMP;
        wr_pend_d = load_write;
        wr_addr_d = wr_addr_q;
        wr_word0_d = wr_word0_q;
        wr_sel0_d = wr_sel0_q;
        if (load_write) begin
            wr_addr_d = addr_i;
            wr_word0_d = wdata_i;
            wr_sel0_d = byte_write_sel_n_i;
        end
    end

    // write capture registers
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            phase_q <= ddr_sio_sram_pkg::PH_TRUE;
            wr_pend_q <= ddr_sio_sram_pkg::RST_PEND;
            wr_addr_q <= '0;
            wr_word0_q <= '0;
            wr_sel0_q <= '1;
        end else begin
            phase_q <= phase_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            wr_word0_q <= wr_word0_d;
            wr_sel0_q <= wr_sel0_d;
        end
    end

    // ****************************************************************
    // array update
    // ****************************************************************
    // both halves are written together once the burst is complete
    always_ff @(posedge core_clk_i) begin
        if (commit_write) begin
            mem_w0[wr_addr_q] <= merged0;
            mem_w1[wr_addr_q] <= merged1;
        end
    end

    // ****************************************************************
    // read path: next values
    // ****************************************************************
    // a new read load wins over the consumption of an older pending read
    always_comb begin
        rd_pend_d = rd_pend_q;
        rd_buf0_d = rd_buf0_q;
        rd_buf1_d = rd_buf1_q;
        rd_hold1_d = rd_hold1_q;
        drive1_d = drive1_q;
        rdata_d = rdata_q;
        oe_d = oe_q;
        echo_d = echo_q;
        if (out_true) begin
            echo_d = 1'b1;
            if (rd_pend_q) begin
                rdata_d = rd_buf0_q;
                rd_hold1_d = rd_buf1_q;
                oe_d = 1'b1;
                drive1_d = 1'b1;
                rd_pend_d = 1'b0;
            end else begin
                oe_d = 1'b0;
                drive1_d = 1'b0;
            end
        end else if (out_comp) begin
            echo_d = 1'b0;
            if (drive1_q) begin
                rdata_d = rd_hold1_q;
                drive1_d = 1'b0;
            end
        end
        if (load_read) begin
            rd_pend_d = 1'b1;
            rd_buf0_d = mem_w0[addr_i];
            rd_buf1_d = mem_w1[addr_i];
        end
    end

    // read path registers
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rd_pend_q <= ddr_sio_sram_pkg::RST_PEND;
            rd_buf0_q <= '0;
            rd_buf1_q <= '0;
            rd_hold1_q <= '0;
            drive1_q <= 1'b0;
            rdata_q <= '0;
            oe_q <= ddr_sio_sram_pkg::RST_OE;
            echo_q <= ddr_sio_sram_pkg::RST_ECHO;
        end else begin
            rd_pend_q <= rd_pend_d;
            rd_buf0_q <= rd_buf0_d;
            rd_buf1_q <= rd_buf1_d;
            rd_hold1_q <= rd_hold1_d;
            drive1_q <= drive1_d;
            rdata_q <= rdata_d;
            oe_q <= oe_d;
            echo_q <= echo_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // all outputs come straight from flip-flops, except echo_strobe_n_o, which is the inverse of echo_q
    assign rdata_o = rdata_q;
    assign rdata_oe_o = oe_q;
    assign echo_strobe_o = echo_q;
    assign echo_strobe_n_o = !echo_q;
    assign phase_comp_o = (phase_q == ddr_sio_sram_pkg::PH_COMP);

endmodule : ddr_sio_sram_port

// file: testbench/ddr_sio_sram_port_properties.sv
// concurrent checks on the ports of the double-data-rate sram port
module ddr_sio_sram_port_properties #(
    parameter int DATA_W = 36
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic load_strobe_n_i,
    input wire logic read_write_i,
    input wire logic single_clock_mode_i,
    input wire logic out_clk_rise_i,
    input wire logic out_clk_n_rise_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic rdata_oe_o,
    input wire logic echo_strobe_o,
    input wire logic echo_strobe_n_o,
    input wire logic phase_comp_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // cycles since the last read load in single clock mode
    // ****************************************************************
    logic [2:0] idle_q;
    logic [2:0] idle_d;
    logic rd_load;
    assign rd_load = !load_strobe_n_i && read_write_i && !phase_comp_o;
    // counter saturates at seven, cleared in dual clock mode
    always_comb begin
        idle_d = idle_q;
        if (!single_clock_mode_i || rd_load) begin
            idle_d = 3'h0;
        end else if (idle_q != 3'h7) begin
            idle_d = idle_q + 3'h1;
        end
    end
    // registers the counter
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            idle_q <= 3'h0;
        end else begin
            idle_q <= idle_d;
        end
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    reset_vals_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $fell(sys_rst_i) |-> !rdata_oe_o && rdata_o == '0 && !phase_comp_o)
        else $error("outputs not at reset values");
    phase_toggle_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        1'b1 |=> phase_comp_o != $past(phase_comp_o))
        else $error("capture phase did not alternate");
    echo_pair_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        echo_strobe_n_o == !echo_strobe_o)
        else $error("echo strobes not complementary");
    echo_true_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !single_clock_mode_i && out_clk_rise_i |=> echo_strobe_o)
        else $error("echo strobe not set by output edge");
    echo_comp_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !single_clock_mode_i && out_clk_n_rise_i |=> !echo_strobe_o)
        else $error("echo strobe not cleared by output edge");
    read_drive_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        rd_load && single_clock_mode_i |-> ##[1:4] rdata_oe_o)
        else $error("read data not driven in time");
    read_release_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        idle_q >= 3'h6 |-> !rdata_oe_o)
        else $error("read bus driven with no read");
    word_echo_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        single_clock_mode_i && $rose(rdata_oe_o) |-> echo_strobe_o ##1 !echo_strobe_o)
        else $error("burst words not on alternate edges");
endmodule : ddr_sio_sram_port_properties

bind ddr_sio_sram_port ddr_sio_sram_port_properties #(.DATA_W(DATA_W)) u_props (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .load_strobe_n_i(load_strobe_n_i),
    .read_write_i(read_write_i), .single_clock_mode_i(single_clock_mode_i),
    .out_clk_rise_i(out_clk_rise_i), .out_clk_n_rise_i(out_clk_n_rise_i),
    .rdata_o(rdata_o), .rdata_oe_o(rdata_oe_o), .echo_strobe_o(echo_strobe_o),
    .echo_strobe_n_o(echo_strobe_n_o), .phase_comp_o(phase_comp_o));

// file: testbench/out_clk_model.sv
// output clock source of the memory controller, able to stall alternate periods
module out_clk_model (
    input wire logic clk_i,
    input wire logic phase_comp_i,
    input wire logic slow_i,
    output logic rise_o = 1'b0,
    output logic rise_n_o = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic skip_q = 1'b0;
    // one edge per capture point, both edges of a period skipped together
    always @(negedge clk_i) begin
        if (!phase_comp_i) begin
            skip_q = slow_i && !skip_q;
        end
        rise_o <= !phase_comp_i && !skip_q;
        rise_n_o <= phase_comp_i && !skip_q;
    end
endmodule : out_clk_model

// file: testbench/tb_ddr_sio_sram_port.sv
// self-checking bench for the double-data-rate sram port
module tb_ddr_sio_sram_port;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DW = ddr_sio_sram_pkg::WIDTH_X36;
    localparam int AW = ddr_sio_sram_pkg::ADDR_W_X36;
    localparam int LW = ddr_sio_sram_pkg::BYTE_LANE_W;
    localparam int SW = DW / LW;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ld_n = 1'b1, rw = 1'b0, single = 1'b1, slow = 1'b0;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0, rdata;
    logic [SW-1:0] sel_n = '1;
    logic oe, echo, echo_n, phase, rise, rise_n;
    logic [DW-1:0] m0 [8], m1 [8];
    logic [31:0] seed = 32'h4;
    int failures = 0, samples_checked = 0;
    // ****************************************************************
    // clock, device and far side
    // ****************************************************************
    always #12.5 clk = ~clk;
    ddr_sio_sram_port #(.DATA_W(DW)) dut (.core_clk_i(clk), .sys_rst_i(rst),
        .load_strobe_n_i(ld_n), .read_write_i(rw), .addr_i(addr), .wdata_i(wdata),
        .byte_write_sel_n_i(sel_n), .single_clock_mode_i(single), .out_clk_rise_i(rise),
        .out_clk_n_rise_i(rise_n), .rdata_o(rdata), .rdata_oe_o(oe), .echo_strobe_o(echo),
        .echo_strobe_n_o(echo_n), .phase_comp_o(phase));
    out_clk_model u_ctrl (.clk_i(clk), .phase_comp_i(phase), .slow_i(slow), .rise_o(rise),
        .rise_n_o(rise_n));
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // merges a written word into the old one lane by lane
    function automatic logic [DW-1:0] merge(logic [DW-1:0] o, logic [DW-1:0] n,
                                            logic [SW-1:0] s);
        for (int i = 0; i < SW; i++) if (!s[i]) o[i*LW +: LW] = n[i*LW +: LW];
        return o;
    endfunction : merge
    // slot seven stands for the top address
    function automatic logic [AW-1:0] amap(int i);
        return (i == 7) ? '1 : AW'(i);
    endfunction : amap
    task automatic end_sim();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic check(logic ok, string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
            if (msg == "timeout") end_sim();
        end
    endtask : check
    // waits at most twenty cycles for a level on a signal
    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(n < 20, "timeout");
    endtask : wait_for
    // moves to the falling edge inside a true-edge cycle
    task automatic align();
        @(negedge clk);
        if (phase === 1'b1) @(negedge clk);
    endtask : align
    // write burst; a stray load in the second cycle must be ignored
    task automatic wr(int i, logic [SW-1:0] s0, logic [SW-1:0] s1);
        logic [DW-1:0] d0, d1;
        d0 = DW'({rnd(), rnd()});
        d1 = DW'({rnd(), rnd()});
        align();
        ld_n = 1'b0; rw = 1'b0; addr = amap(i); wdata = d0; sel_n = s0;
        @(negedge clk);
        ld_n = 1'(rnd()); rw = 1'(rnd()); addr = AW'(rnd()); wdata = d1; sel_n = s1;
        m0[i] = merge(m0[i], d0, s0);
        m1[i] = merge(m1[i], d1, s1);
    endtask : wr
    // read burst, then idle until the read bus is released
    task automatic rd(int i, logic sm);
        single = sm;
        slow = 1'(rnd());
        align();
        ld_n = 1'b0; rw = 1'b1; addr = amap(i);
        @(negedge clk);
        ld_n = 1'b1; addr = AW'(rnd()); sel_n = SW'(rnd());
        wait_for(oe, 1'b1);
        check(rdata === m0[i], "first read word wrong");
        // the second word lands on the same edge that clears the echo strobe
        wait_for(echo, 1'b0);
        check(rdata === m1[i] && oe === 1'b1, "second read word wrong");
        wait_for(oe, 1'b0);
        check(oe === 1'b0, "read bus not released");
    endtask : rd
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) wr(i, '0, '0);
        for (int i = 0; i < 8; i++) rd(i, 1'(i));
        $display("test fill and read back done");
        for (int t = 0; t < 60; t++) begin
            if (1'(rnd())) wr(rnd() % 8, SW'(rnd()), SW'(rnd()));
            else rd(rnd() % 8, 1'(rnd()));
        end
        $display("test random traffic done");
        // let the stray second-cycle load pass, then idle the strobe before reset
        @(negedge clk);
        ld_n = 1'b1;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check(oe === 1'b0 && phase === 1'b0, "reset state wrong");
        check(rdata === '0 && echo === 1'b0 && echo_n === 1'b1, "reset outputs");
        for (int i = 0; i < 8; i++) rd(i, 1'(rnd()));
        $display("test reset keeps memory done");
        end_sim();
    end
endmodule : tb_ddr_sio_sram_port
